// ==== ring_redundancy_switching_tb_top.sv ====
/*
 * bench joining device and host ends; a path model decides expectations.
 * assumes the rrs_pkg constants and the link contract of the pair.
 */
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module ring_redundancy_switching_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rrs_pkg::*;
    // ==================================================================
    // stimulus and instances
    // ==================================================================
    logic core_clk = 1'b0, rst = 1'b1, priOn = 1'b1, secOn = 1'b1, frP = 1'b0, frS = 1'b0;
    logic sd = 1'b0, loop = 1'b1, io = 1'b0, comm = 1'b0, hold = 1'b0, recDone = 1'b0, accReq = 1'b0;
    logic txP, txS, term, recNeed, lost, busy, accOk, accFail;
    rrs_out_t cmd;
    logic [1:0] fault;
    int fail_count = 0, compares = 0;
    logic [5:0] cases [8] = '{6'h2E, 6'h2D, 6'h2F, 6'h26, 6'h3E, 6'h0E, 6'h0A, 6'h0D};
    rrs_link_if link();
    always #20 core_clk = ~core_clk;
    // random frame pulses while a port is up
    always @(posedge core_clk) begin
        frP <= priOn && ($urandom % 8 == 0);
        frS <= secOn && ($urandom % 8 == 0);
    end
    rrs_ring_dev i_rrs_ring_dev (.core_clk(core_clk), .rst(rst), .link(link), .rxFrameValidPri(frP),
        .rxFrameValidSec(frS), .shutdownOnErrorSwitch(sd), .loopTopologySwitch(loop), .txPrimaryEn(txP),
        .txSecondaryEn(txS), .chainTerminator(term), .outputCmd(cmd), .channelFault(fault));
    rrs_ring_host i_rrs_ring_host (.core_clk(core_clk), .rst(rst), .link(link), .cfgIoErrRun(io),
        .cfgCommErrRun(comm), .cfgHoldOnStop(hold), .recoverDone(recDone), .accessReq(accReq),
        .recoverNeeded(recNeed), .dataLost(lost), .accessBusy(busy), .accessOk(accOk), .accessFail(accFail));
    rrs_link_properties i_rrs_link_properties (.core_clk(core_clk), .rst(rst), .ioErrRun(link.ioErrRun),
        .commErrRun(link.commErrRun), .accReq(link.accReq), .path(link.path), .switchFlag(link.switchFlag),
        .lossFlag(link.lossFlag), .systemStop(link.systemStop), .undefinedState(link.undefinedState),
        .accDone(link.accDone), .accErr(link.accErr));
    // ==================================================================
    // path model and helpers
    // ==================================================================
    function automatic int nxt(int p, int lp, int en, int f0, int f1);
        case (p)
            0: return !lp ? 3 : (f0 && f1) ? (en ? 2 : 5) : f0 ? (en ? 1 : 5) : (f1 && !en) ? 5 : 0;
            1: return f1 ? (en ? 2 : 5) : (en ? 1 : 5);
            2, 4: return en ? p : 5;
            3: return lp ? 0 : f0 ? (en ? 4 : 5) : 3;
            default: return 5;
        endcase
    endfunction : nxt
    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    task automatic guard(int n, int lim);
        if (n >= lim) begin
            fail_count++;
            give_verdict();
        end
    endtask : guard
    task automatic give_verdict;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    // one case: {loop, shutdown, io run, comm run, drop pri, drop sec}
    task automatic run_case(logic [5:0] c);
        int p, en, n;
        logic h, mf, sw, ls;
        h = 1'($urandom % 2);
        tick(1);
        {loop, sd, io, comm} <= c[5:2];
        hold <= h;
        rst <= 1'b1;
        priOn <= 1'b1;
        secOn <= 1'b1;
        tick(4);
        rst <= 1'b0;
        tick(40);
        priOn <= !c[1];
        secOn <= !c[0];
        en = (c[3:2] == 2'b11) && !c[4];
        p = 0;
        sw = 1'b0;
        ls = 1'b0;
        mf = c[4] && (c[1] || c[0]);
        for (int i = 0; i < 4; i++) begin
            p = nxt(p, c[5], en, c[1], c[0]);
            sw |= p inside {1, 2, 4};
            ls |= p == 2;
        end
        n = 0;
        while (fault !== {c[0], c[1]} && n < 3000) begin
            @(negedge core_clk);
            n++;
        end
        guard(n, 3000);
        tick(1);
        accReq <= 1'b1;
        tick(1);
        accReq <= 1'b0;
        @(negedge core_clk);
        `CHK("busy", 1'b1, busy)
        n = 0;
        while (accOk !== 1'b1 && accFail !== 1'b1 && n < 1500) begin
            @(negedge core_clk);
            n++;
        end
        guard(n, 1500);
        `CHK("accessOk", p != 5, accOk)
        `CHK("accessFail", p == 5, accFail)
        if (p == 1) `CHK("retried", 1'b1, n > RRS_RETRY_GAP_CYC)
        tick(10);
        @(negedge core_clk);
        `CHK("path", rrs_path_t'(p), link.path)
        `CHK("fault", {c[0], c[1]}, fault)
        `CHK("txPri", p inside {0, 2, 3, 4}, txP)
        `CHK("txSec", p inside {1, 2}, txS)
        `CHK("term", p inside {2, 4}, term)
        `CHK("cmd", p == 5 ? (h ? RRS_OUT_HOLD : RRS_OUT_RESET) : RRS_OUT_RUN, cmd)
        `CHK("stop", p == 5, link.systemStop)
        `CHK("major", mf, link.majorFail)
        `CHK("lost", ls, lost)
        `CHK("recover", sw, recNeed)
        if (p == 5) begin
            tick(1);
            hold <= !h;
            tick(3);
            @(negedge core_clk);
            `CHK("cmdTrack", h ? RRS_OUT_RESET : RRS_OUT_HOLD, cmd)
        end
        if (sw) begin
            tick(1);
            recDone <= 1'b1;
            tick(1);
            recDone <= 1'b0;
            tick(3);
            @(negedge core_clk);
            `CHK("recoverClr", 1'b0, recNeed)
        end
        if (p == 2) begin
            tick(1);
            priOn <= 1'b1;
            tick(100);
            priOn <= 1'b0;
            n = 0;
            while (fault[0] !== 1'b1 && n < 3000) begin
                @(negedge core_clk);
                n++;
            end
            guard(n, 3000);
            tick(3);
            @(negedge core_clk);
            `CHK("undefined", 1'b1, link.undefinedState)
        end
    endtask : run_case
    // main sequence
    initial begin
        void'($urandom(32'hAC5FFD54));
        for (int k = 0; k < 8; k++) begin
            run_case(cases[k]);
        end
        give_verdict();
    end
endmodule : ring_redundancy_switching_tb_top

// ==== rrs_link_if.sv ====
/*
 * link between the redundancy device end and the controller (host) end.
 * assumes both ends run on the same core clock; no clocking block.
 */
interface rrs_link_if;
    import rrs_pkg::*;

    // ==================================================================
    // host to device
    // ==================================================================
    logic ioErrRun;     // io module error policy is continue
    logic commErrRun;   // subunit comm error policy is continue
    logic holdOnStop;   // stopped outputs held instead of reset
    logic switchAck;    // one-cycle clear of switchover flags
    logic accReq;       // one-cycle substation access request

    // ==================================================================
    // device to host
    // ==================================================================
    rrs_path_t path;
    logic switchFlag;   // sticky: any switchover happened
    logic lossFlag;     // sticky: loop split into chains, data may be lost
    logic majorFail;    // channel error raised as major failure
    logic systemStop;   // system halted
    logic undefinedState; // further break after split
    logic accDone;      // one-cycle answer to accReq
    logic accErr;       // with accDone: access failed

    modport dev (
        input ioErrRun, commErrRun, holdOnStop, switchAck, accReq,
        output path, switchFlag, lossFlag, majorFail, systemStop, undefinedState, accDone, accErr
    );
    modport host (
        output ioErrRun, commErrRun, holdOnStop, switchAck, accReq,
        input path, switchFlag, lossFlag, majorFail, systemStop, undefinedState, accDone, accErr
    );
endinterface : rrs_link_if

// ==== rrs_link_properties.sv ====
/*
 * concurrent checks on the link between the device and host ends.
 * assumes instantiation beside rrs_link_if, one clock, sync reset.
 */
module rrs_link_properties
    import rrs_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic ioErrRun,
    input wire logic commErrRun,
    input wire logic accReq,
    input wire rrs_pkg::rrs_path_t path,
    input wire logic switchFlag,
    input wire logic lossFlag,
    input wire logic systemStop,
    input wire logic undefinedState,
    input wire logic accDone,
    input wire logic accErr
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==================================================================
    // link properties
    // ==================================================================
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    acc_answer_a: assert property (accReq |=> accDone) else $error("access not answered");
    stop_flag_a: assert property ((path == RRS_PATH_STOP) == systemStop) else $error("stop flag wrong");
    stop_sticky_a: assert property (path == RRS_PATH_STOP |=> path == RRS_PATH_STOP) else $error("left stop");
    split_loss_a: assert property (path != RRS_PATH_SPLIT ##1 path == RRS_PATH_SPLIT |-> lossFlag)
        else $error("split without loss flag");
    policy_gate_a: assert property (path == RRS_PATH_PRIMARY && !(ioErrRun && commErrRun)
        |=> !(path inside {RRS_PATH_SECONDARY, RRS_PATH_SPLIT})) else $error("switched while disabled");
    no_return_a: assert property (path == RRS_PATH_SECONDARY
        |=> path inside {RRS_PATH_SECONDARY, RRS_PATH_SPLIT, RRS_PATH_STOP}) else $error("bad exit");
    settle_refuse_a: assert property ($rose(switchFlag) ##[0:8] accReq |=> accErr)
        else $error("access taken during settle");
    undef_split_a: assert property ($rose(undefinedState) |-> $past(path) == RRS_PATH_SPLIT)
        else $error("undefined outside split");
endmodule : rrs_link_properties

// ==== rrs_pkg.sv ====
/*
 * shared constants and types for the ring redundancy switching pair:
 * fault timeout, settle window, retry spacing, path states, output commands.
 * assumes a single 25 MHz core clock on both ends.
 */
package rrs_pkg;

    // ==================================================================
    // clock and timing
    // ==================================================================
    localparam int RRS_CLK_MHZ = 25;
    localparam int RRS_TMR_W = 12;
    // silence on a port longer than this declares the segment broken
    localparam int RRS_FRAME_TIMEOUT_US = 100;
    localparam int RRS_FRAME_TIMEOUT_CYC = RRS_FRAME_TIMEOUT_US * RRS_CLK_MHZ;
    // substation accesses are refused for this long after a switchover
    localparam int RRS_SETTLE_US = 20;
    localparam int RRS_SETTLE_CYC = RRS_SETTLE_US * RRS_CLK_MHZ;
    // host waits this long between two attempts of one access
    localparam int RRS_RETRY_GAP_US = 10;
    localparam int RRS_RETRY_GAP_CYC = RRS_RETRY_GAP_US * RRS_CLK_MHZ;
    localparam logic [RRS_TMR_W-1:0] RRS_TIMEOUT_LAST = RRS_TMR_W'(RRS_FRAME_TIMEOUT_CYC - 1);
    localparam logic [RRS_TMR_W-1:0] RRS_SETTLE_LOAD = RRS_TMR_W'(RRS_SETTLE_CYC);
    localparam logic [RRS_TMR_W-1:0] RRS_RETRY_GAP_LOAD = RRS_TMR_W'(RRS_RETRY_GAP_CYC);
    localparam logic [RRS_TMR_W-1:0] RRS_TMR_ZERO = 12'h000;

    // ==================================================================
    // retry count and reset values
    // ==================================================================
    localparam int RRS_RETRY_W = 3;
    localparam logic [RRS_RETRY_W-1:0] RRS_RETRY_MAX = 3'h3;
    localparam logic [RRS_RETRY_W-1:0] RRS_RETRY_ZERO = 3'h0;
    localparam logic [1:0] RRS_FAULT_NONE = 2'h0;

    // ==================================================================
    // types
    // ==================================================================
    // transmission path the device is using
    typedef enum logic [2:0] {
        RRS_PATH_PRIMARY,
        RRS_PATH_SECONDARY,
        RRS_PATH_SPLIT,
        RRS_PATH_CHAIN,
        RRS_PATH_FOLD,
        RRS_PATH_STOP
    } rrs_path_t;

    // command to the output modules
    typedef enum logic [1:0] {
        RRS_OUT_RUN,
        RRS_OUT_RESET,
        RRS_OUT_HOLD
    } rrs_out_t;

endpackage : rrs_pkg

// ==== rrs_ring_dev.sv ====
/*
 * device end of ring redundancy switching: per-port frame watchdogs,
 * loop/chain path state machine, switchover flags, output command,
 * and the answer to substation accesses.
 * assumes frame-valid pulses and switch levels synchronous to core_clk;
 * the host end drives the policy levels and acknowledges switchovers.
 */
// Notes on behaviour
// (R1) loop: primary carries traffic, secondary stands idle
// (R2) one ring broken: move to intact ring
// (R3) both rings broken: split into two chains
// (R4) flag loop-to-chain split; host checks and recovers
// (R5) loop switching needs run policies, shutdown off, loop on
// (R6) after split, run or stop follows switch and policy
// (R7) shutdown switch on: channel error is major failure
// (R8) chain break: last reachable station terminates chain
// (R9) fold-back needs run policies, shutdown off, loop off
// (R10) further break after split: state flagged undefined
// (R11) repair after split only with everything powered off
// (R12) host retries failed accesses after a switchover
// (R13) chain fold-back needs correct port cabling
// (R14) port silent past timeout marks segment broken
module rrs_ring_dev (
    input wire logic core_clk,
    input wire logic rst,
    rrs_link_if.dev link,
    input wire logic rxFrameValidPri,
    input wire logic rxFrameValidSec,
    input wire logic shutdownOnErrorSwitch,
    input wire logic loopTopologySwitch,
    output logic txPrimaryEn,
    output logic txSecondaryEn,
    output logic chainTerminator,
    output rrs_pkg::rrs_out_t outputCmd,
    output logic [1:0] channelFault
);
    import rrs_pkg::*;

    // ==================================================================
    // helpers
    // ==================================================================
    // watchdog count: clears on a frame, saturates at the last count
    function automatic logic [RRS_TMR_W-1:0] rrsWdogNext(
        input logic [RRS_TMR_W-1:0] cnt,
        input logic frame
    );
        logic [RRS_TMR_W-1:0] res;
        res = cnt;
        if (frame) begin
            res = RRS_TMR_ZERO;
        end else if (cnt != RRS_TIMEOUT_LAST) begin
            res = cnt + 12'h001;
        end
        return res;
    endfunction : rrsWdogNext

    // true for paths that are a switchover away from normal operation
    function automatic logic rrsIsSwitched(input rrs_path_t p);
        return (p == RRS_PATH_SECONDARY) || (p == RRS_PATH_SPLIT) || (p == RRS_PATH_FOLD);
    endfunction : rrsIsSwitched

    // ==================================================================
    // state
    // ==================================================================
    rrs_path_t stateQ, stateD;
    logic [RRS_TMR_W-1:0] wdogQ [2];
    logic [1:0] faultQ;
    logic [1:0] faultPrevQ;
    logic [RRS_TMR_W-1:0] settleQ;
    logic switchFlagQ, lossFlagQ, majorFailQ, undefinedQ;
    logic accDoneQ, accErrQ;
    logic txPriQ, txSecQ, termQ, stopQ;
    rrs_out_t outCmdQ;

    // ==================================================================
    // decoding
    // ==================================================================
    // enabling conditions from switches and controller policy
    wire logic policyRun = link.ioErrRun & link.commErrRun;
    wire logic loopSwitchEn = policyRun & ~shutdownOnErrorSwitch & loopTopologySwitch; // R5
    wire logic foldBackEn = policyRun & ~shutdownOnErrorSwitch & ~loopTopologySwitch; // R9
    wire logic stopCause = shutdownOnErrorSwitch | ~policyRun; // R6
    wire logic [1:0] rxFrame = {rxFrameValidSec, rxFrameValidPri};
    wire logic [1:0] faultNew = faultQ & ~faultPrevQ;
    wire logic anyFault = |faultQ;
    wire logic bothFault = &faultQ;
    wire logic enterSwitched = (stateD != stateQ) && rrsIsSwitched(stateD);
    wire logic enterSplit = (stateD == RRS_PATH_SPLIT) && (stateQ != RRS_PATH_SPLIT);
    wire logic enterStop = (stateD == RRS_PATH_STOP) && (stateQ != RRS_PATH_STOP);
    // access refused while settling, stopped or on a broken working path
    wire logic pathBroken = ((stateQ == RRS_PATH_PRIMARY) && faultQ[0])
        || ((stateQ == RRS_PATH_SECONDARY) && faultQ[1])
        || ((stateQ == RRS_PATH_CHAIN) && faultQ[0]);
    wire logic accFail = (settleQ != RRS_TMR_ZERO) || (stateQ == RRS_PATH_STOP) || pathBroken;

    // ==================================================================
    // per-port frame watchdogs
    // ==================================================================
    // a segment is broken once its port has been silent for the timeout
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wdogQ[0] <= RRS_TMR_ZERO;
            wdogQ[1] <= RRS_TMR_ZERO;
            faultQ <= RRS_FAULT_NONE;
            faultPrevQ <= RRS_FAULT_NONE;
        end else begin
            for (int i = 0; i < 2; i++) begin
                wdogQ[i] <= rrsWdogNext(wdogQ[i], rxFrame[i]);
                faultQ[i] <= ~rxFrame[i] & (wdogQ[i] == RRS_TIMEOUT_LAST); // R14
            end
            faultPrevQ <= faultQ;
        end
    end

    // ==================================================================
    // path state machine
    // ==================================================================
    // next path from the port faults and the enabling conditions
    always_comb begin
        stateD = stateQ;
        case (stateQ)
            RRS_PATH_PRIMARY: begin
                if (!loopTopologySwitch) begin
                    stateD = RRS_PATH_CHAIN;
                end else if (bothFault) begin
                    stateD = loopSwitchEn ? RRS_PATH_SPLIT : RRS_PATH_STOP; // R3
                end else if (faultQ[0]) begin
                    stateD = loopSwitchEn ? RRS_PATH_SECONDARY : RRS_PATH_STOP; // R2
                end else if (faultQ[1] && !loopSwitchEn) begin
                    stateD = RRS_PATH_STOP; // R7
                end
            end
            RRS_PATH_SECONDARY: begin
                if (faultQ[1]) begin
                    stateD = loopSwitchEn ? RRS_PATH_SPLIT : RRS_PATH_STOP; // R3
                end else if (stopCause) begin
                    stateD = RRS_PATH_STOP;
                end
            end
            RRS_PATH_SPLIT: begin
                if (stopCause) begin
                    stateD = RRS_PATH_STOP; // R6
                end
            end
            RRS_PATH_CHAIN: begin
                if (loopTopologySwitch) begin
                    stateD = RRS_PATH_PRIMARY;
                end else if (faultQ[0]) begin
                    stateD = foldBackEn ? RRS_PATH_FOLD : RRS_PATH_STOP; // R8
                end
            end
            RRS_PATH_FOLD: begin
                if (stopCause) begin
                    stateD = RRS_PATH_STOP; // R9
                end
            end
            RRS_PATH_STOP: begin
                stateD = RRS_PATH_STOP;
            end
            default: begin
                stateD = RRS_PATH_STOP;
            end
        endcase
    end

    // path register; reset always loads primary, topology switch off then moves it to chain
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stateQ <= RRS_PATH_PRIMARY;
        end else begin
            stateQ <= stateD;
        end
    end

    // ==================================================================
    // port drive per path
    // ==================================================================
    // secondary idle in loop, both used and terminated when split
    always_ff @(posedge core_clk) begin
        if (rst) begin
            txPriQ <= 1'b0;
            txSecQ <= 1'b0;
            termQ <= 1'b0;
            stopQ <= 1'b0;
        end else begin
            txPriQ <= (stateD == RRS_PATH_PRIMARY) || (stateD == RRS_PATH_SPLIT)
                || (stateD == RRS_PATH_CHAIN) || (stateD == RRS_PATH_FOLD); // R1
            txSecQ <= (stateD == RRS_PATH_SECONDARY) || (stateD == RRS_PATH_SPLIT); // R2
            termQ <= (stateD == RRS_PATH_SPLIT) || (stateD == RRS_PATH_FOLD); // R8
            stopQ <= (stateD == RRS_PATH_STOP); // R6
        end
    end

    // ==================================================================
    // status flags
    // ==================================================================
    // sticky switchover flags; a new switchover wins over the clear
    always_ff @(posedge core_clk) begin
        if (rst) begin
            switchFlagQ <= 1'b0;
            lossFlagQ <= 1'b0;
            majorFailQ <= 1'b0;
            undefinedQ <= 1'b0;
        end else begin
            switchFlagQ <= enterSwitched | (switchFlagQ & ~link.switchAck);
            lossFlagQ <= enterSplit | (lossFlagQ & ~link.switchAck); // R4
            if (shutdownOnErrorSwitch && anyFault && (stateQ != RRS_PATH_STOP)) begin
                majorFailQ <= 1'b1; // R7
            end
            if ((stateQ == RRS_PATH_SPLIT) && (|faultNew)) begin
                undefinedQ <= 1'b1; // R10
            end
        end
    end

    // ==================================================================
    // output command
    // ==================================================================
    // stopped outputs are reset or held as the host selects
    always_ff @(posedge core_clk) begin
        if (rst) begin
            outCmdQ <= RRS_OUT_RUN;
        end else if (stateD == RRS_PATH_STOP) begin
            outCmdQ <= link.holdOnStop ? RRS_OUT_HOLD : RRS_OUT_RESET; // R7
        end else begin
            outCmdQ <= RRS_OUT_RUN;
        end
    end

    // ==================================================================
    // substation access answer
    // ==================================================================
    // settle window after each switchover; accesses inside it fail
    always_ff @(posedge core_clk) begin
        if (rst) begin
            settleQ <= RRS_TMR_ZERO;
            accDoneQ <= 1'b0;
            accErrQ <= 1'b0;
        end else begin
            if (enterSwitched || enterStop) begin
                settleQ <= RRS_SETTLE_LOAD; // R12
            end else if (settleQ != RRS_TMR_ZERO) begin
                settleQ <= settleQ - 12'h001;
            end
            accDoneQ <= link.accReq;
            accErrQ <= link.accReq & accFail;
        end
    end

    // ==================================================================
    // outputs
    // ==================================================================
    assign txPrimaryEn = txPriQ;
    assign txSecondaryEn = txSecQ;
    assign chainTerminator = termQ;
    assign outputCmd = outCmdQ;
    assign channelFault = faultQ;
    assign link.path = stateQ;
    assign link.switchFlag = switchFlagQ;
    assign link.lossFlag = lossFlagQ;
    assign link.majorFail = majorFailQ;
    assign link.systemStop = stopQ;
    assign link.undefinedState = undefinedQ;
    assign link.accDone = accDoneQ;
    assign link.accErr = accErrQ;

endmodule : rrs_ring_dev

// ==== rrs_ring_host.sv ====
/*
 * host end of ring redundancy switching: drives the error policies,
 * reports switchovers for recovery and acknowledges them, and retries
 * failed substation accesses.
 * assumes user inputs synchronous to core_clk and a device end on the link.
 */
module rrs_ring_host (
    input wire logic core_clk,
    input wire logic rst,
    rrs_link_if.host link,
    input wire logic cfgIoErrRun,
    input wire logic cfgCommErrRun,
    input wire logic cfgHoldOnStop,
    input wire logic recoverDone,
    input wire logic accessReq,
    output logic recoverNeeded,
    output logic dataLost,
    output logic accessBusy,
    output logic accessOk,
    output logic accessFail
);
    import rrs_pkg::*;

    typedef enum logic [1:0] {RRS_H_IDLE, RRS_H_WAIT, RRS_H_GAP} rrs_hstate_t;

    rrs_hstate_t hStateQ;
    logic [RRS_RETRY_W-1:0] triesQ;
    logic [RRS_TMR_W-1:0] gapQ;
    logic ioRunQ, commRunQ, holdQ, ackQ, reqQ;
    logic recoverQ, lostQ, okQ, failQ;

    // ==================================================================
    // policy and switchover recovery
    // ==================================================================
    // user confirms recovery, which clears the device switchover flags
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ioRunQ <= 1'b0;
            commRunQ <= 1'b0;
            holdQ <= 1'b0;
            ackQ <= 1'b0;
            recoverQ <= 1'b0;
            lostQ <= 1'b0;
        end else begin
            ioRunQ <= cfgIoErrRun;
            commRunQ <= cfgCommErrRun;
            holdQ <= cfgHoldOnStop;
            recoverQ <= link.switchFlag & ~ackQ; // R4
            lostQ <= link.lossFlag & ~ackQ;
            ackQ <= recoverDone & recoverQ & ~ackQ;
        end
    end

    // ==================================================================
    // access with retry
    // ==================================================================
    // failed accesses are retried after a gap, up to the retry limit
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hStateQ <= RRS_H_IDLE;
            triesQ <= RRS_RETRY_ZERO;
            gapQ <= RRS_TMR_ZERO;
            reqQ <= 1'b0;
            okQ <= 1'b0;
            failQ <= 1'b0;
        end else begin
            reqQ <= 1'b0;
            okQ <= 1'b0;
            failQ <= 1'b0;
            case (hStateQ)
                RRS_H_IDLE: begin
                    if (accessReq) begin
                        reqQ <= 1'b1;
                        triesQ <= RRS_RETRY_ZERO;
                        hStateQ <= RRS_H_WAIT;
                    end
                end
                RRS_H_WAIT: begin
                    if (link.accDone && !link.accErr) begin
                        okQ <= 1'b1;
                        hStateQ <= RRS_H_IDLE;
                    end else if (link.accDone && (triesQ == RRS_RETRY_MAX)) begin
                        failQ <= 1'b1;
                        hStateQ <= RRS_H_IDLE;
                    end else if (link.accDone) begin
                        triesQ <= triesQ + 3'h1; // R12
                        gapQ <= RRS_RETRY_GAP_LOAD;
                        hStateQ <= RRS_H_GAP;
                    end
                end
                RRS_H_GAP: begin
                    if (gapQ == RRS_TMR_ZERO) begin
                        reqQ <= 1'b1; // R12
                        hStateQ <= RRS_H_WAIT;
                    end else begin
                        gapQ <= gapQ - 12'h001;
                    end
                end
                default: begin
                    hStateQ <= RRS_H_IDLE;
                end
            endcase
        end
    end

    // ==================================================================
    // outputs
    // ==================================================================
    assign link.ioErrRun = ioRunQ;
    assign link.commErrRun = commRunQ;
    assign link.holdOnStop = holdQ;
    assign link.switchAck = ackQ;
    assign link.accReq = reqQ;
    assign recoverNeeded = recoverQ;
    assign dataLost = lostQ;
    assign accessBusy = (hStateQ != RRS_H_IDLE);
    assign accessOk = okQ;
    assign accessFail = failQ;

endmodule : rrs_ring_host
